// ### rtl/hmal_regs.svh
// register offsets, field positions and timing counts of the alarm logic
`ifndef HMAL_REGS_SVH
`define HMAL_REGS_SVH
`define HMAL_PORT_INDEX 16'h0005
`define HMAL_PORT_DATA 16'h0006
`define HMAL_IDX_RESET 7'h00
`define HMAL_IDX_SYS_OT 7'h39
`define HMAL_IDX_SYS_HY 7'h3A
`define HMAL_IDX_CPU_OT 7'h3B
`define HMAL_IDX_CPU_HY 7'h3C
`define HMAL_IDX_AUX_OT 7'h3D
`define HMAL_IDX_AUX_HY 7'h3E
`define HMAL_IDX_STAT0 7'h41
`define HMAL_IDX_STAT1 7'h42
`define HMAL_IDX_STAT2 7'h43
`define HMAL_IDX_MASK0 7'h44
`define HMAL_IDX_MASK1 7'h45
`define HMAL_IDX_MASK2 7'h47
`define HMAL_IDX_OVT_CFG 7'h18
`define HMAL_IDX_INTR_CLR 7'h46
`define HMAL_IDX_TEMP_CFG 7'h4C
`define HMAL_IDX_USER 7'h53
`define HMAL_IDX_BEEP0 7'h56
`define HMAL_IDX_BEEP1 7'h57
`define HMAL_IDX_CPU_OVTM 7'h5A
`define HMAL_IDX_AUX_OVTM 7'h5B
`define HMAL_BIT_ONE_TIME 5
`define HMAL_BIT_CPU_COMP 6
`define HMAL_BIT_CPU_OVTEN 3
`define HMAL_BIT_AUX_OVTEN 4
`define HMAL_BIT_SYS_OVTEN 6
`define HMAL_BIT_SYS_OVTM 4
`define HMAL_BIT_OVTM 1
`define HMAL_BIT_INTR_CLR 7
`define HMAL_BIT_BEEP_GLOBAL 7
`define HMAL_BIT_USER_ALARM 5
`define HMAL_HYST_COMPARATOR 8'h7F
`define HMAL_CLK_HZ 100000000
`define HMAL_TONE_LO_HZ 600
`define HMAL_TONE_HI_HZ 1200
`define HMAL_SEGMENT_MS 500
`define HMAL_HALF_LO_CYC (`HMAL_CLK_HZ / (2 * `HMAL_TONE_LO_HZ))
`define HMAL_HALF_HI_CYC (`HMAL_CLK_HZ / (2 * `HMAL_TONE_HI_HZ))
`define HMAL_SEGMENT_CYC ((`HMAL_CLK_HZ / 1000) * `HMAL_SEGMENT_MS)
`endif

// ### rtl/hmal_pkg.sv
// types of the alarm logic
package hmal_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} hmal_io_req_t;
	typedef struct packed {
		logic [8:0] volt;
		logic [4:0] fan;
	} hmal_limits_t;
	typedef logic [2:0][7:0] hmal_temps_t;
endpackage : hmal_pkg

// ### rtl/hmal_alarm_logic.sv
// alarm, interrupt, intrusion and beeper logic of the hardware monitor
`timescale 1ns/1ns
`include "hmal_regs.svh"
// Contract
// - system sensor uses two-time mode when hysteresis below limit, one-time bit clear.
// - two-time: event on rising above limit and on later falling below hysteresis.
// - one-time bit set: event only on rising; re-arms after falling below hysteresis.
// - raised interrupt stays until software has read every status register.
// - cpu/aux comparator bit set: events while above limit until below hysteresis.
// - cpu/aux comparator bit clear: two-time behaviour, one event each crossing.
// - alarm pin is management interrupt when function bit one, else over-temperature.
// - in over-temperature mode each sensor has its own pin enable.
// - over-temperature comparator mode: pin asserted from above limit to below hysteresis.
// - over-temperature interrupt mode: pin latched on crossings until status reads.
// - intrusion high-to-low edge is latched; latch and live level are readable.
// - intrusion latch clears only on clear bit written one then zero, or alias.
// - beeper pin carries the alarm tone when its function bit is zero.
// - beeper sources: voltage, temperature, fan, intrusion low, user alarm bit.
// - beeper needs global enable and the source's own enable.
// - open-drain beeper rests low; alternates 600 Hz and 1.2 kHz, half second each.
// - index port at base plus 5, data port at base plus 6.
// - index port holds seven-bit pointer, reset zero; bit 7 reads zero.
// - data port reads and writes the location the pointer selects.
// - system hysteresis of 127 selects comparator: events while above limit.
module hmal_alarm_logic #(
	parameter logic [31:0] HALF_LO_CYC = `HMAL_HALF_LO_CYC,
	parameter logic [31:0] HALF_HI_CYC = `HMAL_HALF_HI_CYC,
	parameter logic [31:0] SEGMENT_CYC = `HMAL_SEGMENT_CYC
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire hmal_pkg::hmal_io_req_t ioReq,
	output logic [7:0] ioRdata,
	input wire logic [7:0] ioBaseHigh,
	input wire logic [7:0] ioBaseLow,
	input wire logic pinFuncSmi,
	input wire logic beepPinSel,
	input wire logic intrClrAlias,
	input wire hmal_pkg::hmal_temps_t temps,
	input wire hmal_pkg::hmal_limits_t limits,
	input wire logic caseOpen_n,
	output logic alarmOut_n,
	output logic beeperOut,
	output logic beeperOe_n
);
	import hmal_pkg::*;

	// ************************************************************
	// host port decode
	// ************************************************************
	logic [7:0] regs_r [0:127];
	logic [6:0] idxPtr_r;
	logic [7:0] ioRdata_r;
	logic [15:0] ioBase;
	logic hitIndex;
	logic hitData;
	logic [7:0] rdMux;
	logic [7:0] stat0_r;
	logic [7:0] stat1_r;
	logic [7:0] stat2_r;
	logic [2:0] seen_r;
	logic clearAll;
	logic [2:0] readStat;
	logic caseSync_r;
	logic intrLatch_r;

	assign ioBase = {ioBaseHigh, ioBaseLow};
	assign hitIndex = (ioReq.addr == 16'(ioBase + `HMAL_PORT_INDEX));
	assign hitData = (ioReq.addr == 16'(ioBase + `HMAL_PORT_DATA));

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			idxPtr_r <= `HMAL_IDX_RESET;
		else if (hitIndex && ioReq.wr)
			idxPtr_r <= ioReq.wdata[6:0];
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < 128; i++)
				regs_r[i] <= 8'h00;
		end
		else if (hitData && ioReq.wr)
			regs_r[idxPtr_r] <= ioReq.wdata;
	end

	always_comb
	begin
		case (idxPtr_r)
			`HMAL_IDX_STAT0: rdMux = stat0_r;
			`HMAL_IDX_STAT1: rdMux = stat1_r;
			`HMAL_IDX_STAT2: rdMux = {stat2_r[7:3], !caseSync_r, intrLatch_r, stat2_r[0]};
			default: rdMux = regs_r[idxPtr_r];
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			ioRdata_r <= 8'h00;
		else if (hitIndex && ioReq.rd)
			ioRdata_r <= {1'b0, idxPtr_r};
		else if (hitData && ioReq.rd)
			ioRdata_r <= rdMux;
		else if (ioReq.rd)
			ioRdata_r <= 8'h00;
	end
	assign ioRdata = ioRdata_r;

	// ************************************************************
	// status read tracking
	// ************************************************************
	assign readStat[0] = hitData && ioReq.rd && idxPtr_r == `HMAL_IDX_STAT0;
	assign readStat[1] = hitData && ioReq.rd && idxPtr_r == `HMAL_IDX_STAT1;
	assign readStat[2] = hitData && ioReq.rd && idxPtr_r == `HMAL_IDX_STAT2;
	assign clearAll = &(seen_r | readStat);

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			seen_r <= 3'h0;
		else if (clearAll)
			seen_r <= 3'h0;
		else
			seen_r <= seen_r | readStat;
	end

	// ************************************************************
	// temperature event logic
	// ************************************************************
	logic [7:0] cfgTemp;
	logic [2:0] hot_r;
	logic [2:0] hotNxt;
	logic [2:0] tempEvt;
	logic [2:0] crossEvt;
	logic [2:0] ovtEn;
	logic [2:0] ovtIntMode;
	logic [2:0] ovtLatch_r;
	logic [2:0][7:0] otLim;
	logic [2:0][7:0] hyLim;

	assign cfgTemp = regs_r[`HMAL_IDX_TEMP_CFG];
	assign otLim[0] = regs_r[`HMAL_IDX_SYS_OT];
	assign hyLim[0] = regs_r[`HMAL_IDX_SYS_HY];
	assign otLim[1] = regs_r[`HMAL_IDX_CPU_OT];
	assign hyLim[1] = regs_r[`HMAL_IDX_CPU_HY];
	assign otLim[2] = regs_r[`HMAL_IDX_AUX_OT];
	assign hyLim[2] = regs_r[`HMAL_IDX_AUX_HY];
	assign ovtEn[0] = regs_r[`HMAL_IDX_OVT_CFG][`HMAL_BIT_SYS_OVTEN];
	assign ovtEn[1] = cfgTemp[`HMAL_BIT_CPU_OVTEN];
	assign ovtEn[2] = cfgTemp[`HMAL_BIT_AUX_OVTEN];
	assign ovtIntMode[0] = regs_r[`HMAL_IDX_OVT_CFG][`HMAL_BIT_SYS_OVTM];
	assign ovtIntMode[1] = regs_r[`HMAL_IDX_CPU_OVTM][`HMAL_BIT_OVTM];
	assign ovtIntMode[2] = regs_r[`HMAL_IDX_AUX_OVTM][`HMAL_BIT_OVTM];

	for (genvar k = 0; k < 3; k++)
	begin : g_sensor
		logic above;
		logic below;
		logic comp;
		logic oneTime;
		assign above = $signed(temps[k]) > $signed(otLim[k]);
		assign below = $signed(temps[k]) < $signed(hyLim[k]);
		assign hotNxt[k] = hot_r[k] ? !below : above;
		assign crossEvt[k] = (above && !hot_r[k]) || (below && hot_r[k]);
		if (k == 0)
		begin : g_sys
			assign comp = (hyLim[0] == `HMAL_HYST_COMPARATOR);
			assign oneTime = cfgTemp[`HMAL_BIT_ONE_TIME];
			assign tempEvt[0] = comp ? above :
				(above && !hot_r[0]) || (below && hot_r[0] && !oneTime);
		end
		else
		begin : g_cpu_aux
			assign comp = cfgTemp[`HMAL_BIT_CPU_COMP];
			assign oneTime = 1'b0;
			assign tempEvt[k] = comp ? hotNxt[k] : crossEvt[k];
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			hot_r <= 3'h0;
		else
			hot_r <= hotNxt;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			ovtLatch_r <= 3'h0;
		else
			ovtLatch_r <= (ovtLatch_r & {3{!clearAll}}) | crossEvt;
	end

	// ************************************************************
	// voltage, fan and intrusion events
	// ************************************************************
	hmal_limits_t limPrev_r;
	logic [8:0] voltEvt;
	logic [4:0] fanEvt;
	logic caseMeta_r;
	logic casePrev_r;
	logic intrEvt;
	logic clrBit_r;
	logic aliasPrev_r;
	logic intrClear;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			limPrev_r <= '0;
		else
			limPrev_r <= limits;
	end
	assign voltEvt = limits.volt & ~limPrev_r.volt;
	assign fanEvt = limits.fan & ~limPrev_r.fan;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			caseMeta_r <= 1'b1;
			caseSync_r <= 1'b1;
			casePrev_r <= 1'b1;
		end
		else
		begin
			caseMeta_r <= caseOpen_n;
			caseSync_r <= caseMeta_r;
			casePrev_r <= caseSync_r;
		end
	end
	assign intrEvt = casePrev_r && !caseSync_r;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			clrBit_r <= 1'b0;
			aliasPrev_r <= 1'b0;
		end
		else
		begin
			clrBit_r <= regs_r[`HMAL_IDX_INTR_CLR][`HMAL_BIT_INTR_CLR];
			aliasPrev_r <= intrClrAlias;
		end
	end
	assign intrClear = (clrBit_r &&
		!regs_r[`HMAL_IDX_INTR_CLR][`HMAL_BIT_INTR_CLR]) ||
		(aliasPrev_r && !intrClrAlias);

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			intrLatch_r <= 1'b0;
		else if (intrEvt)
			intrLatch_r <= 1'b1;
		else if (intrClear)
			intrLatch_r <= 1'b0;
	end

	// ************************************************************
	// latched status and alarm pin
	// ************************************************************
	logic irqAny;
	logic ovtAny;
	logic alarmOut_r;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stat0_r <= 8'h00;
			stat1_r <= 8'h00;
			stat2_r <= 8'h00;
		end
		else
		begin
			stat0_r <= (stat0_r & {8{!clearAll}}) | voltEvt[7:0];
			stat1_r <= (stat1_r & {8{!clearAll}}) | {fanEvt, tempEvt};
			stat2_r <= (stat2_r & {8{!clearAll}}) |
				{6'h00, intrEvt, voltEvt[8]};
		end
	end

	assign irqAny = |(stat0_r & ~regs_r[`HMAL_IDX_MASK0]) ||
		|(stat1_r & ~regs_r[`HMAL_IDX_MASK1]) ||
		|(stat2_r & ~regs_r[`HMAL_IDX_MASK2]);
	assign ovtAny = |(ovtEn & ((ovtIntMode & ovtLatch_r) |
		(~ovtIntMode & hot_r)));

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			alarmOut_r <= 1'b1;
		else
			alarmOut_r <= pinFuncSmi ? !irqAny : !ovtAny;
	end
	assign alarmOut_n = alarmOut_r;

	// ************************************************************
	// beeper
	// ************************************************************
	logic [16:0] beepSrc;
	logic [16:0] beepEn;
	logic beepActive;
	logic [31:0] segCnt_r;
	logic [31:0] halfCnt_r;
	logic toneHigh_r;
	logic wave_r;
	logic beepOe_r;
	logic [7:0] userReg;

	assign userReg = regs_r[`HMAL_IDX_USER];
	assign beepSrc = {userReg[`HMAL_BIT_USER_ALARM], !caseSync_r,
		limits.fan[2], limits.fan[1], limits.fan[0] | limits.fan[3] |
		limits.fan[4], hot_r, limits.volt};
	assign beepEn = {userReg[1:0], regs_r[`HMAL_IDX_BEEP1][6:0],
		regs_r[`HMAL_IDX_BEEP0]};
	assign beepActive = !beepPinSel &&
		regs_r[`HMAL_IDX_BEEP1][`HMAL_BIT_BEEP_GLOBAL] &&
		|(beepSrc & beepEn);

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			segCnt_r <= 32'h0;
			toneHigh_r <= 1'b0;
		end
		else if (!beepActive)
		begin
			segCnt_r <= 32'h0;
			toneHigh_r <= 1'b0;
		end
		else if (segCnt_r == SEGMENT_CYC - 32'h1)
		begin
			segCnt_r <= 32'h0;
			toneHigh_r <= !toneHigh_r;
		end
		else
			segCnt_r <= segCnt_r + 32'h1;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			halfCnt_r <= 32'h0;
			wave_r <= 1'b0;
		end
		else if (!beepActive)
		begin
			halfCnt_r <= 32'h0;
			wave_r <= 1'b0;
		end
		else if (halfCnt_r >= (toneHigh_r ? HALF_HI_CYC : HALF_LO_CYC) - 32'h1)
		begin
			halfCnt_r <= 32'h0;
			wave_r <= !wave_r;
		end
		else
			halfCnt_r <= halfCnt_r + 32'h1;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			beepOe_r <= 1'b1;
		else
			beepOe_r <= !beepActive || !wave_r;
	end
	assign beeperOe_n = !beepOe_r;
	assign beeperOut = 1'b0;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	ptr_write_a: assert property (hitIndex && ioReq.wr |=> idxPtr_r == $past(ioReq.wdata[6:0]))
		else $error("index pointer not loaded");
	idx_read_a: assert property (hitIndex && ioReq.rd && !ioReq.wr |=> ioRdata[7] == 1'b0 && ioRdata[6:0] == $past(idxPtr_r))
		else $error("index readback wrong");
	data_write_a: assert property (hitData && ioReq.wr |=> regs_r[$past(idxPtr_r)] == $past(ioReq.wdata))
		else $error("data write lost");
	stat_hold_a: assert property (stat1_r[1] && !clearAll |=> stat1_r[1])
		else $error("status dropped before reads");
	smi_pin_a: assert property (pinFuncSmi && irqAny |=> !alarmOut_n)
		else $error("interrupt pin not asserted");
	ovt_comp_a: assert property (!pinFuncSmi && ovtEn[0] && !ovtIntMode[0] && hot_r[0] |=> !alarmOut_n)
		else $error("over-temperature pin not asserted");
	no_repeat_a: assert property (hot_r[0] && hyLim[0] != `HMAL_HYST_COMPARATOR && !g_sensor[0].below |-> !tempEvt[0])
		else $error("repeat event while hot");
	one_time_a: assert property (cfgTemp[`HMAL_BIT_ONE_TIME] && hyLim[0] != `HMAL_HYST_COMPARATOR && hot_r[0] |-> !tempEvt[0])
		else $error("one-time fall event raised");
	cpu_comp_a: assert property (cfgTemp[`HMAL_BIT_CPU_COMP] && hotNxt[1] |=> stat1_r[1])
		else $error("comparator event missing");
	intr_latch_a: assert property (casePrev_r && !caseSync_r |=> intrLatch_r)
		else $error("intrusion not latched");
	intr_keep_a: assert property (intrLatch_r && !intrClear |=> intrLatch_r)
		else $error("intrusion cleared without clear");
	beep_rest_a: assert property (!beepActive |=> !beeperOe_n && !beeperOut)
		else $error("beeper not resting low");

	beep_cov: cover property (beepActive ##1 !beeperOe_n ##[1:1000] beeperOe_n);
	smi_cov: cover property (pinFuncSmi && !alarmOut_n ##1 clearAll);
	intr_cov: cover property (intrLatch_r ##1 intrClear);
endmodule : hmal_alarm_logic

// ### verif/hmal_host_model.sv
// host model issuing indexed port cycles
`timescale 1ns/1ns
module hmal_host_model (
	input wire logic mclk,
	input wire logic [15:0] baseAddr,
	input wire logic [7:0] ioRdata,
	output hmal_pkg::hmal_io_req_t ioReq
);
	import hmal_pkg::*;
	initial ioReq = '0;
	// one strobe cycle, then release with inverted lines
	task cyc(input logic [15:0] a, input logic r, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge mclk);
		ioReq = '{addr: a, rd: r, wr: !r, wdata: d};
		@(negedge mclk);
		ioReq = '{addr: ~a, rd: 1'h0, wr: 1'h0, wdata: ~d};
		@(negedge mclk);
		q = ioRdata;
	endtask : cyc
	task wreg(input logic [6:0] i, input logic [7:0] d);
		logic [7:0] q;
		cyc(baseAddr + 16'h0005, 1'h0, {1'h0, i}, q);
		cyc(baseAddr + 16'h0006, 1'h0, d, q);
	endtask : wreg
	task rreg(input logic [6:0] i, output logic [7:0] q);
		cyc(baseAddr + 16'h0005, 1'h0, {1'h0, i}, q);
		cyc(baseAddr + 16'h0006, 1'h1, 8'h00, q);
	endtask : rreg
	// reads every status register to rearm the pin
	task rdStat();
		logic [7:0] q;
		rreg(7'h41, q);
		rreg(7'h42, q);
		rreg(7'h43, q);
	endtask : rdStat
	// intrusion latch clear, one then zero
	task clrCase();
		wreg(7'h46, 8'h80);
		wreg(7'h46, 8'h00);
	endtask : clrCase
endmodule : hmal_host_model

// ### verif/testbench.sv
// self-checking bench of the alarm logic
`timescale 1ns/1ns
module testbench;
	import hmal_pkg::*;
	logic mclk, reset_n, pinFuncSmi, beepPinSel, intrClrAlias, caseOpen_n;
	logic alarmOut_n, beeperOut, beeperOe_n;
	logic [7:0] ioRdata, ioBaseHigh, ioBaseLow, q;
	logic [15:0] ba;
	hmal_io_req_t ioReq;
	hmal_temps_t temps;
	hmal_limits_t limits;
	int nErrors, nCompared, cycles, n;
	assign ba = {ioBaseHigh, ioBaseLow};
	hmal_alarm_logic #(.HALF_LO_CYC(32'h4), .HALF_HI_CYC(32'h2),
		.SEGMENT_CYC(32'h28)) u_dut (.mclk(mclk), .reset_n(reset_n),
		.ioReq(ioReq), .ioRdata(ioRdata), .ioBaseHigh(ioBaseHigh),
		.ioBaseLow(ioBaseLow), .pinFuncSmi(pinFuncSmi),
		.beepPinSel(beepPinSel), .intrClrAlias(intrClrAlias),
		.temps(temps), .limits(limits), .caseOpen_n(caseOpen_n),
		.alarmOut_n(alarmOut_n), .beeperOut(beeperOut),
		.beeperOe_n(beeperOe_n));
	hmal_host_model u_host (.mclk(mclk), .baseAddr(ba), .ioRdata(ioRdata),
		.ioReq(ioReq));
	// ************************************************
	// helpers
	// ************************************************
	always #5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cycles = cycles + 1;
		if (cycles == 32'h00004E20)
		begin
			nErrors = nErrors + 1;
			tally_and_finish();
		end
	end
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	function logic pick(input bit b);
		return b ? beeperOe_n : alarmOut_n;
	endfunction : pick
	task waitFor(input bit b, input logic e, input int lim);
		int c;
		c = 0;
		while (pick(b) !== e && c < lim)
		begin
			@(negedge mclk);
			c++;
		end
		chk({7'h00, pick(b)}, {7'h00, e});
	endtask : waitFor
	task holdFor(input bit b, input logic e, input int lim);
		logic ok;
		ok = 1'h1;
		repeat (lim)
		begin
			@(negedge mclk);
			if (pick(b) !== e)
				ok = 1'h0;
		end
		chk({7'h00, ok}, 8'h01);
	endtask : holdFor
	task halfLen(output int c);
		logic v;
		v = beeperOe_n;
		c = 0;
		while (beeperOe_n === v && c < 100)
		begin
			@(negedge mclk);
			c++;
		end
	endtask : halfLen
	task settle();
		u_host.rdStat();
		waitFor(0, 1'h1, 6);
	endtask : settle
	// ************************************************
	// scenarios
	// ************************************************
	task t_ports();
		chk({7'h00, beeperOe_n}, 8'h00);
		u_host.cyc(ba + 16'h0005, 1'h1, 8'h00, q);
		chk(q, 8'h00);
		u_host.cyc(ba + 16'h0005, 1'h0, 8'hB9, q);
		u_host.cyc(ba + 16'h0005, 1'h1, 8'h00, q);
		chk(q, 8'h39);
		u_host.cyc(ba + 16'h0006, 1'h0, 8'h55, q);
		u_host.cyc(16'h0005, 1'h0, 8'h3A, q);
		u_host.cyc(ba + 16'h0006, 1'h1, 8'h00, q);
		chk(q, 8'h55);
		u_host.cyc(ba + 16'h0007, 1'h1, 8'h00, q);
		chk(q, 8'h00);
	endtask : t_ports
	task t_sys_two();
		u_host.wreg(7'h39, 8'h50);
		u_host.wreg(7'h3A, 8'h40);
		settle();
		temps[0] = 8'h60;
		waitFor(0, 1'h0, 6);
		u_host.rreg(7'h41, q);
		u_host.rreg(7'h42, q);
		chk(q & 8'h01, 8'h01);
		holdFor(0, 1'h0, 4);
		u_host.rreg(7'h43, q);
		waitFor(0, 1'h1, 4);
		holdFor(0, 1'h1, 20);
		temps[0] = 8'h30;
		waitFor(0, 1'h0, 6);
		u_host.wreg(7'h45, 8'h01);
		waitFor(0, 1'h1, 4);
		u_host.wreg(7'h45, 8'h00);
		waitFor(0, 1'h0, 4);
		settle();
	endtask : t_sys_two
	task t_sys_one();
		u_host.wreg(7'h4C, 8'h20);
		settle();
		temps[0] = 8'h60;
		waitFor(0, 1'h0, 6);
		settle();
		temps[0] = 8'h30;
		holdFor(0, 1'h1, 12);
		temps[0] = 8'h60;
		waitFor(0, 1'h0, 6);
		temps[0] = 8'h30;
		u_host.wreg(7'h4C, 8'h00);
	endtask : t_sys_one
	task t_sys_comp();
		u_host.wreg(7'h3A, 8'h7F);
		settle();
		temps[0] = 8'h60;
		waitFor(0, 1'h0, 6);
		u_host.rdStat();
		holdFor(0, 1'h0, 10);
		temps[0] = 8'h30;
		settle();
		u_host.wreg(7'h3A, 8'h40);
	endtask : t_sys_comp
	task t_cpu();
		u_host.wreg(7'h3B, 8'h50);
		u_host.wreg(7'h3C, 8'h40);
		u_host.wreg(7'h4C, 8'h40);
		settle();
		temps[1] = 8'h60;
		waitFor(0, 1'h0, 6);
		temps[1] = 8'h45;
		u_host.rdStat();
		holdFor(0, 1'h0, 10);
		temps[1] = 8'h30;
		settle();
		u_host.wreg(7'h4C, 8'h00);
		temps[1] = 8'h60;
		waitFor(0, 1'h0, 6);
		settle();
		temps[1] = 8'h30;
		waitFor(0, 1'h0, 6);
		settle();
	endtask : t_cpu
	task t_ovt();
		pinFuncSmi = 1'h0;
		temps[0] = 8'h60;
		holdFor(0, 1'h1, 10);
		u_host.wreg(7'h18, 8'h40);
		waitFor(0, 1'h0, 6);
		temps[0] = 8'h45;
		holdFor(0, 1'h0, 8);
		temps[0] = 8'h30;
		waitFor(0, 1'h1, 6);
		u_host.wreg(7'h18, 8'h50);
		u_host.wreg(7'h5A, 8'h02);
		u_host.wreg(7'h5B, 8'h02);
		settle();
		temps[0] = 8'h60;
		waitFor(0, 1'h0, 6);
		holdFor(0, 1'h0, 8);
		settle();
		temps[0] = 8'h30;
		waitFor(0, 1'h0, 6);
		settle();
		u_host.wreg(7'h18, 8'h00);
		pinFuncSmi = 1'h1;
	endtask : t_ovt
	task t_intr();
		settle();
		caseOpen_n = 1'h0;
		waitFor(0, 1'h0, 8);
		u_host.rreg(7'h43, q);
		chk(q & 8'h06, 8'h06);
		caseOpen_n = 1'h1;
		u_host.rdStat();
		u_host.rreg(7'h43, q);
		chk(q & 8'h06, 8'h02);
		u_host.clrCase();
		u_host.rreg(7'h43, q);
		chk(q & 8'h02, 8'h00);
		caseOpen_n = 1'h0;
		waitFor(0, 1'h0, 8);
		caseOpen_n = 1'h1;
		intrClrAlias = 1'h1;
		@(negedge mclk);
		intrClrAlias = 1'h0;
		repeat (2) @(negedge mclk);
		u_host.rreg(7'h43, q);
		chk(q & 8'h02, 8'h00);
		settle();
	endtask : t_intr
	task t_beep();
		u_host.wreg(7'h53, 8'h22);
		holdFor(1, 1'h0, 12);
		u_host.wreg(7'h57, 8'h80);
		waitFor(1, 1'h1, 8);
		halfLen(n);
		chk(n[7:0], 8'h04);
		repeat (14) halfLen(n);
		chk(n[7:0], 8'h02);
		beepPinSel = 1'h1;
		@(negedge mclk);
		holdFor(1, 1'h0, 12);
		beepPinSel = 1'h0;
		u_host.wreg(7'h53, 8'h00);
		holdFor(1, 1'h0, 12);
		u_host.wreg(7'h56, 8'h01);
		limits.volt = 9'h001;
		waitFor(1, 1'h1, 8);
		u_host.wreg(7'h57, 8'h00);
		waitFor(1, 1'h0, 4);
		limits.volt = 9'h000;
	endtask : t_beep
	task tally_and_finish();
		if (nErrors == 0 && nCompared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		mclk = 1'h0;
		reset_n = 1'h0;
		pinFuncSmi = 1'h1;
		beepPinSel = 1'h0;
		intrClrAlias = 1'h0;
		caseOpen_n = 1'h1;
		ioBaseHigh = 8'h02;
		ioBaseLow = 8'h90;
		temps = '0;
		limits = '0;
		nErrors = 0;
		nCompared = 0;
		cycles = 0;
		repeat (5) @(negedge mclk);
		reset_n = 1'h1;
		t_ports();
		t_sys_two();
		t_sys_one();
		t_sys_comp();
		t_cpu();
		t_ovt();
		t_intr();
		t_beep();
		tally_and_finish();
	end
endmodule : testbench
